// ==== src/chip_config_regs.sv ====
// Function
// - Bit order is held once and shows in both bit 6 and bit 1; either written high selects LSB first.
// - Writing either soft-reset bit returns all registers but port configuration to defaults.
// - Both soft-reset bits clear themselves one cycle after the soft reset.
// - The speed field sits in bits 5:4 with 00, 01 and 10 for modes I, II and III.
// - A stored speed value is applied only when the update address is written.
// - Two registers hold one enable per channel, all set by default, gating local writes.
module chip_config_regs #(
  parameter logic [7:0] PART_ID = 8'h5c // Arbitrary identification value.
) (
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic sclk, // Serial control clock from the host.
  input wire logic cs_n, // Serial frame select, active low.
  input wire logic sdio_in, // Serial data pin, input side.
  output logic sdio_out, // Serial data pin, output side.
  output logic sdio_oe, // Serial data output enable.
  output logic lsb_first, // Current bit order.
  output logic soft_reset, // One-cycle soft reset pulse to the chip.
  output cfg_pkg::speed_mode_t speed_mode, // Applied speed mode.
  output logic [7:0] channel_enable, // Channel enables, H down to A.
  output logic local_wr, // One-cycle strobe for a local register write.
  output logic [12:0] local_wr_addr, // Address of the local write.
  output logic [7:0] local_wr_data, // Data of the local write.
  output logic [7:0] local_wr_chan // Channels that take the local write.
);

  // ==========================================================================
  // Link side and crossings
  // ==========================================================================
  logic [39:0] image;
  logic [39:0] live_image;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic frame_done;
  logic cs_s;
  logic cs_prev;
  logic done_s;
  logic wr_go;
  logic [1:0] speed_sel;
  logic [3:0] chan_upper;
  logic [3:0] chan_lower;
  logic [7:0] port_cfg_rd;
  logic done_low_seen;

  spi_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .srst(srst),
    .lsb_first(lsb_first),
    .image(image),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .frame_done(frame_done)
  );

  sync_2ff #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk(clk_sys),
    .rst(srst),
    .d(cs_n),
    .q(cs_s)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_done_sync (
    .clk(clk_sys),
    .rst(srst),
    .d(frame_done),
    .q(done_s)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_s;
    end
  end

  // A select pulse with no clock edges leaves the done flag of the last write standing.
  // Counting a frame only when the flag was seen low inside it stops that replay.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_low_seen <= 1'b0;
    end else if (cs_s && !cs_prev) begin
      done_low_seen <= 1'b0;
    end else if (!cs_s && !done_s) begin
      done_low_seen <= 1'b1;
    end
  end

  // The end of a write frame is the event; the held words are still by then.
  assign wr_go = cs_s && !cs_prev && done_s && done_low_seen;

  // ==========================================================================
  // Port configuration
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lsb_first <= 1'b0;
    end else if (wr_go && wr_addr == cfg_pkg::ADDR_PORT_CFG) begin
      lsb_first <= wr_data[cfg_pkg::BIT_LSB_HI] | wr_data[cfg_pkg::BIT_LSB_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wr_go && wr_addr == cfg_pkg::ADDR_PORT_CFG
        && (wr_data[cfg_pkg::BIT_SRST_HI] | wr_data[cfg_pkg::BIT_SRST_LO]);
    end
  end

  always_comb begin
    port_cfg_rd = cfg_pkg::PORT_CFG_FIXED;
    port_cfg_rd[cfg_pkg::BIT_LSB_HI] = lsb_first;
    port_cfg_rd[cfg_pkg::BIT_LSB_LO] = lsb_first;
    port_cfg_rd[cfg_pkg::BIT_SRST_HI] = soft_reset;
    port_cfg_rd[cfg_pkg::BIT_SRST_LO] = soft_reset;
  end

  // ==========================================================================
  // Speed grade and update
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      speed_sel <= cfg_pkg::SPEED_MODE_I;
    end else if (wr_go && wr_addr == cfg_pkg::ADDR_SPEED) begin
      speed_sel <= wr_data[cfg_pkg::SPEED_LSB +: 2];
    end
  end

  // Holding the applied mode apart lets software stage a change safely.
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      speed_mode <= cfg_pkg::SPEED_MODE_I;
    end else if (wr_go && wr_addr == cfg_pkg::ADDR_UPDATE) begin
      speed_mode <= cfg_pkg::speed_mode_t'(speed_sel);
    end
  end

  // ==========================================================================
  // Channel index
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      chan_upper <= cfg_pkg::CHAN_UPPER_RESET[3:0];
      chan_lower <= cfg_pkg::CHAN_LOWER_RESET[3:0];
    end else if (wr_go && wr_addr == cfg_pkg::ADDR_CHAN_UPPER) begin
      chan_upper <= wr_data[cfg_pkg::CHAN_W-1:0];
    end else if (wr_go && wr_addr == cfg_pkg::ADDR_CHAN_LOWER) begin
      chan_lower <= wr_data[cfg_pkg::CHAN_W-1:0];
    end
  end

  assign channel_enable = {chan_upper, chan_lower};

  // Addresses decoded here; every other write is passed on as a local write.
  function automatic logic in_map(input logic [12:0] a);
    return a == cfg_pkg::ADDR_PORT_CFG || a == cfg_pkg::ADDR_PART_ID
      || a == cfg_pkg::ADDR_SPEED || a == cfg_pkg::ADDR_UPDATE
      || a == cfg_pkg::ADDR_CHAN_UPPER || a == cfg_pkg::ADDR_CHAN_LOWER;
  endfunction : in_map

  // Writes outside this map go to the channel logic with the current enables.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      local_wr <= 1'b0;
      local_wr_addr <= 13'h0000;
      local_wr_data <= 8'h00;
      local_wr_chan <= 8'h00;
    end else begin
      local_wr <= 1'b0;
      if (wr_go && !in_map(wr_addr)) begin
        local_wr <= 1'b1;
        local_wr_addr <= wr_addr;
        local_wr_data <= wr_data;
        local_wr_chan <= channel_enable;
      end
    end
  end

  // ==========================================================================
  // Read image for the link side
  // ==========================================================================
  assign live_image = {cfg_pkg::CHAN_LOWER_FIXED | {4'h0, chan_lower},
    {4'h0, chan_upper},
    {2'h0, speed_sel, 4'h0},
    PART_ID,
    port_cfg_rd};

  // The image is frozen while a frame is open, so the link reads a still word.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      image <= {cfg_pkg::CHAN_LOWER_RESET, cfg_pkg::CHAN_UPPER_RESET, 8'h00, PART_ID,
        cfg_pkg::PORT_CFG_FIXED};
    end else if (cs_s && cs_prev) begin
      image <= live_image;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  property p_lsb_mirror;
    cs_s && cs_prev |=> image[cfg_pkg::IMG_PORT*8 + cfg_pkg::BIT_LSB_HI] == $past(lsb_first)
      && image[cfg_pkg::IMG_PORT*8 + cfg_pkg::BIT_LSB_LO] == $past(lsb_first);
  endproperty
  a_lsb_mirror: assert property (p_lsb_mirror) else $error("bit order copies differ");

  property p_lsb_write;
    wr_go && wr_addr == cfg_pkg::ADDR_PORT_CFG
      |=> lsb_first == ($past(wr_data[cfg_pkg::BIT_LSB_HI]) | $past(wr_data[cfg_pkg::BIT_LSB_LO]));
  endproperty
  a_lsb_write: assert property (p_lsb_write) else $error("bit order not taken");

  property p_srst_defaults;
    soft_reset |=> chan_upper == cfg_pkg::CHAN_UPPER_RESET[3:0]
      && chan_lower == cfg_pkg::CHAN_LOWER_RESET[3:0] && speed_sel == 2'h0
      && speed_mode == cfg_pkg::SPEED_MODE_I && $stable(lsb_first);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults) else $error("soft reset defaults wrong");

  property p_srst_clear;
    soft_reset |=> !soft_reset ##0 !port_cfg_rd[cfg_pkg::BIT_SRST_HI]
      && !port_cfg_rd[cfg_pkg::BIT_SRST_LO];
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset bits stuck");

  property p_speed_store;
    wr_go && wr_addr == cfg_pkg::ADDR_SPEED
      |=> speed_sel == $past(wr_data[cfg_pkg::SPEED_LSB +: 2])
      && live_image[cfg_pkg::IMG_SPEED*8 +: 8] == {2'h0, speed_sel, 4'h0};
  endproperty
  a_speed_store: assert property (p_speed_store) else $error("speed field not stored");

  property p_speed_hold;
    !(wr_go && wr_addr == cfg_pkg::ADDR_UPDATE) && !soft_reset |=> $stable(speed_mode);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed applied without update");

  property p_speed_apply;
    wr_go && wr_addr == cfg_pkg::ADDR_UPDATE && !soft_reset |=> speed_mode == $past(speed_sel);
  endproperty
  a_speed_apply: assert property (p_speed_apply) else $error("update did not apply");

  property p_chan_gate;
    local_wr |-> local_wr_chan == channel_enable && $past(wr_go) && $stable(channel_enable);
  endproperty
  a_chan_gate: assert property (p_chan_gate) else $error("local write mask wrong");

  property p_id_fixed;
    live_image[cfg_pkg::IMG_ID*8 +: 8] == PART_ID && image[cfg_pkg::IMG_ID*8 +: 8] == PART_ID;
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("identifier changed");

  property p_srst_source;
    soft_reset |-> $past(wr_go && wr_addr == cfg_pkg::ADDR_PORT_CFG)
      && ($past(wr_data[cfg_pkg::BIT_SRST_HI]) || $past(wr_data[cfg_pkg::BIT_SRST_LO]));
  endproperty
  a_srst_source: assert property (p_srst_source) else $error("soft reset unrequested");

  property p_id_ignored;
    wr_go && wr_addr == cfg_pkg::ADDR_PART_ID |=> !local_wr && !soft_reset
      && $stable(channel_enable) && $stable(speed_sel) && $stable(lsb_first);
  endproperty
  a_id_ignored: assert property (p_id_ignored) else $error("identifier write acted");

  property p_chan_write;
    wr_go && wr_addr == cfg_pkg::ADDR_CHAN_UPPER && !soft_reset
      |=> chan_upper == $past(wr_data[cfg_pkg::CHAN_W-1:0]);
  endproperty
  a_chan_write: assert property (p_chan_write) else $error("upper enables not stored");

  property p_local_payload;
    wr_go && !in_map(wr_addr) |=> local_wr && local_wr_addr == $past(wr_addr)
      && local_wr_data == $past(wr_data) && local_wr_chan == $past(channel_enable);
  endproperty
  a_local_payload: assert property (p_local_payload) else $error("local write lost");

  property p_local_pulse;
    local_wr |=> !local_wr;
  endproperty
  a_local_pulse: assert property (p_local_pulse) else $error("local strobe too long");

  property p_stale_ignored;
    cs_s && !cs_prev && !done_low_seen |=> !local_wr && $stable(channel_enable)
      && $stable(speed_sel) && $stable(lsb_first);
  endproperty
  a_stale_ignored: assert property (p_stale_ignored) else $error("empty frame replayed");

  c_soft_reset: cover property (wr_go ##1 soft_reset);
  c_speed_update: cover property (wr_go && wr_addr == cfg_pkg::ADDR_UPDATE ##1 speed_mode != 2'h0);
  c_local_write: cover property (local_wr && local_wr_chan != 8'hff);
  c_lsb_mode: cover property ($rose(lsb_first));

endmodule : chip_config_regs

// ==== src/cfg_pkg.sv ====
package cfg_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADDR_PART_ID = 13'h001;
  localparam logic [12:0] ADDR_SPEED = 13'h002;
  localparam logic [12:0] ADDR_CHAN_UPPER = 13'h004;
  localparam logic [12:0] ADDR_CHAN_LOWER = 13'h005;
  localparam logic [12:0] ADDR_UPDATE = 13'h0ff;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int BIT_LSB_HI = 6;
  localparam int BIT_LSB_LO = 1;
  localparam int BIT_SRST_HI = 5;
  localparam int BIT_SRST_LO = 2;
  localparam int SPEED_LSB = 4;
  localparam int CHAN_W = 4;
  localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
  localparam logic [7:0] CHAN_UPPER_RESET = 8'h0f;
  localparam logic [7:0] CHAN_LOWER_RESET = 8'h3f;
  localparam logic [7:0] CHAN_LOWER_FIXED = 8'h30;

  typedef enum logic [1:0] {
    SPEED_MODE_I = 2'h0,
    SPEED_MODE_II = 2'h1,
    SPEED_MODE_III = 2'h2
  } speed_mode_t;

  // ==========================================================================
  // Serial frame
  // ==========================================================================
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int INSTR_RNW = 15;

  typedef enum logic [2:0] {
    PH_INSTR = 3'h1,
    PH_DATA = 3'h2,
    PH_DONE = 3'h4
  } phase_t;

  // Byte slots of the register image shared with the link side.
  localparam int IMG_PORT = 0;
  localparam int IMG_ID = 1;
  localparam int IMG_SPEED = 2;
  localparam int IMG_UPPER = 3;
  localparam int IMG_LOWER = 4;
  localparam int IMG_W = 40;

  function automatic logic [7:0] read_byte(input logic [12:0] addr, input logic [39:0] img);
    logic [7:0] r;
    r = 8'h00;
    if (addr == ADDR_PORT_CFG) begin
      r = img[IMG_PORT*8 +: 8];
    end else if (addr == ADDR_PART_ID) begin
      r = img[IMG_ID*8 +: 8];
    end else if (addr == ADDR_SPEED) begin
      r = img[IMG_SPEED*8 +: 8];
    end else if (addr == ADDR_CHAN_UPPER) begin
      r = img[IMG_UPPER*8 +: 8];
    end else if (addr == ADDR_CHAN_LOWER) begin
      r = img[IMG_LOWER*8 +: 8];
    end
    return r;
  endfunction : read_byte

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : rev8

endpackage : cfg_pkg

// ==== src/sync_2ff.sv ====
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // Destination clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic d, // Level from another domain.
  output logic q // Synchronised level.
);

  logic meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sync_2ff

// ==== src/spi_link.sv ====
module spi_link (
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_n, // Frame select, active low.
  input wire logic sdio_in, // Serial data pin, input side.
  input wire logic srst, // System reset, clears link flags at once.
  input wire logic lsb_first, // Bit order level from the register side.
  input wire logic [39:0] image, // Readable registers, held still during frames.
  output logic sdio_out, // Serial data pin, output side.
  output logic sdio_oe, // High while the pin is driven.
  output logic [12:0] wr_addr, // Address of the last write frame.
  output logic [7:0] wr_data, // Data of the last write frame.
  output logic frame_done // Last frame was a complete write.
);

  // ==========================================================================
  // Bit order crossing
  // ==========================================================================
  logic lsb_meta;
  logic lsb_s;

  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      lsb_meta <= 1'b0;
      lsb_s <= 1'b0;
    end else begin
      lsb_meta <= lsb_first;
      lsb_s <= lsb_meta;
    end
  end

  // ==========================================================================
  // Frame sequencing
  // ==========================================================================
  cfg_pkg::phase_t phase;
  logic [4:0] bit_cnt;
  logic [23:0] sh_in;
  logic [15:0] instr;
  logic [7:0] data_in;
  logic [7:0] rd_byte;
  logic [12:0] addr;
  logic rnw;
  logic [2:0] data_idx;

  // In LSB-first order the instruction and the data arrive each reversed.
  always_comb begin
    instr = {sh_in[14:0], sdio_in};
    data_in = {sh_in[6:0], sdio_in};
    if (lsb_s) begin
      instr = {cfg_pkg::rev8(instr[7:0]), cfg_pkg::rev8(instr[15:8])};
      data_in = cfg_pkg::rev8(data_in);
    end
  end

  always_ff @(posedge sclk) begin
    sh_in <= {sh_in[22:0], sdio_in};
  end

  // A frame ends with its own select, since the clock stops between frames.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      phase <= cfg_pkg::PH_INSTR;
      bit_cnt <= 5'h00;
    end else begin
      case (phase)
        cfg_pkg::PH_INSTR: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == cfg_pkg::INSTR_BITS - 5'h01) begin
            phase <= cfg_pkg::PH_DATA;
          end
        end
        cfg_pkg::PH_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == cfg_pkg::FRAME_BITS - 5'h01) begin
            phase <= cfg_pkg::PH_DONE;
          end
        end
        default: begin
          phase <= cfg_pkg::PH_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge sclk) begin
    if (phase == cfg_pkg::PH_INSTR && bit_cnt == cfg_pkg::INSTR_BITS - 5'h01) begin
      rnw <= instr[cfg_pkg::INSTR_RNW];
      addr <= instr[12:0];
      if (lsb_s) begin
        rd_byte <= cfg_pkg::rev8(cfg_pkg::read_byte(instr[12:0], image));
      end else begin
        rd_byte <= cfg_pkg::read_byte(instr[12:0], image);
      end
    end
  end

  // The write words stay still until the register side has taken them.
  always_ff @(posedge sclk) begin
    if (phase == cfg_pkg::PH_DATA && bit_cnt == cfg_pkg::FRAME_BITS - 5'h01 && !rnw) begin
      wr_addr <= addr;
      wr_data <= data_in;
    end
  end

  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      frame_done <= 1'b0;
    end else if (phase == cfg_pkg::PH_INSTR && bit_cnt == 5'h00) begin
      frame_done <= 1'b0;
    end else if (phase == cfg_pkg::PH_DATA && bit_cnt == cfg_pkg::FRAME_BITS - 5'h01) begin
      frame_done <= !rnw;
    end
  end

  // ==========================================================================
  // Read data out, launched on the falling edge
  // ==========================================================================
  assign data_idx = 3'h7 - 3'(bit_cnt - cfg_pkg::INSTR_BITS);

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdio_out <= 1'b0;
    end else if (phase == cfg_pkg::PH_DATA) begin
      sdio_out <= rd_byte[data_idx];
    end
  end

  assign sdio_oe = !cs_n && rnw && phase == cfg_pkg::PH_DATA;

endmodule : spi_link

// ==== test/spi_host_model.sv ====
module spi_host_model (
  output logic sclk, // Serial clock, still between frames.
  output logic cs_n, // Frame select, active low.
  output logic sdio_in, // Resolved level of the data wire.
  input wire logic sdio_out, // Device read data.
  input wire logic sdio_oe // Device drives the wire while high.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic bit_v = 1'b0;
  // A released wire shows the inverse of the last bit, so a stale value never passes.
  assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_v : ~bit_v);
  // A clean rising select edge after time zero puts the link into its idle phase.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end

  // ==========================================================================
  // One 24-bit frame
  // ==========================================================================
  task automatic xfer(input logic rnw, input logic [12:0] addr, input logic [7:0] wdata,
                      input logic lsb, output logic [7:0] rdata);
    logic [23:0] word;
    int idx;
    word = {rnw, 2'h0, addr, wdata};
    rdata = 8'h00;
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      idx = lsb ? ((i < 16) ? i + 8 : i - 16) : 23 - i;
      bit_v = word[idx];
      drv = !(rnw && i >= 16);
      #24 sclk = 1'b1;
      if (rnw && i >= 16) begin
        rdata[lsb ? i - 16 : 23 - i] = sdio_in;
      end
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    drv = 1'b0;
  endtask : xfer

  // A select pulse with no clock must not repeat the previous write.
  task automatic select_only;
    #1;
    cs_n = 1'b0;
    #480 cs_n = 1'b1;
  endtask : select_only
endmodule : spi_host_model

// ==== test/chip_config_channel_index_regs_test.sv ====
module chip_config_channel_index_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3b; // Arbitrary identification value.
  logic clk_sys;
  logic srst;
  wire logic sclk;
  wire logic cs_n;
  wire logic sdio_in;
  logic sdio_out;
  logic sdio_oe;
  logic lsb_first;
  logic soft_reset;
  cfg_pkg::speed_mode_t speed_mode;
  logic [7:0] channel_enable;
  logic local_wr;
  logic [12:0] local_wr_addr;
  logic [7:0] local_wr_data;
  logic [7:0] local_wr_chan;
  int n_errors = 0;
  int compares = 0;
  int n_srst = 0;
  int n_local = 0;

  chip_config_regs #(.PART_ID(ID)) uut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .lsb_first(lsb_first), .soft_reset(soft_reset), .speed_mode(speed_mode),
    .channel_enable(channel_enable), .local_wr(local_wr), .local_wr_addr(local_wr_addr),
    .local_wr_data(local_wr_data), .local_wr_chan(local_wr_chan));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (soft_reset === 1'b1) n_srst++;
    if (local_wr === 1'b1) n_local++;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Writes land 2-3 cycles after the frame; twelve also covers the idle gap.
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
    logic [7:0] r;
    host.xfer(1'b0, a, d, lsb, r);
    repeat (12) @(posedge clk_sys);
  endtask : wr

  task automatic rd_chk(input logic [12:0] a, input logic lsb, input logic [7:0] exp);
    logic [7:0] r;
    host.xfer(1'b1, a, 8'h00, lsb, r);
    repeat (12) @(posedge clk_sys);
    check({8'h00, r}, {8'h00, exp}, "read data");
  endtask : rd_chk

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_defaults;
    check({8'h00, channel_enable}, 16'h00ff, "enables after reset");
    check({15'h0, lsb_first}, 16'h0000, "order after reset");
    rd_chk(cfg_pkg::ADDR_PORT_CFG, 1'b0, 8'h18);
    rd_chk(cfg_pkg::ADDR_CHAN_UPPER, 1'b0, 8'h0f);
    rd_chk(cfg_pkg::ADDR_CHAN_LOWER, 1'b0, 8'h3f);
    rd_chk(13'h003, 1'b0, 8'h00);
    wr(cfg_pkg::ADDR_PART_ID, ~ID, 1'b0);
    rd_chk(cfg_pkg::ADDR_PART_ID, 1'b0, ID);
  endtask : t_defaults

  task automatic t_speed;
    logic [1:0] prev;
    for (int m = 0; m < 3; m++) begin
      prev = speed_mode;
      wr(cfg_pkg::ADDR_SPEED, {2'h0, 2'(m), 4'h0}, 1'b0);
      check({14'h0, speed_mode}, {14'h0, prev}, "speed before update");
      rd_chk(cfg_pkg::ADDR_SPEED, 1'b0, {2'h0, 2'(m), 4'h0});
      wr(cfg_pkg::ADDR_UPDATE, 8'h01, 1'b0);
      check({14'h0, speed_mode}, {14'h0, 2'(m)}, "speed after update");
    end
  endtask : t_speed

  task automatic t_channels;
    int n0;
    n0 = n_local;
    wr(cfg_pkg::ADDR_CHAN_UPPER, 8'h05, 1'b0);
    wr(cfg_pkg::ADDR_CHAN_LOWER, 8'h0a, 1'b0);
    check({8'h00, channel_enable}, 16'h005a, "enables");
    rd_chk(cfg_pkg::ADDR_CHAN_LOWER, 1'b0, 8'h3a);
    wr(13'h011, 8'h06, 1'b0);
    host.select_only();
    repeat (12) @(posedge clk_sys);
    check(16'(n_local - n0), 16'h0001, "local strobes");
    check({8'h00, local_wr_chan}, 16'h005a, "local channels");
    check({3'h0, local_wr_addr}, 16'h0011, "local address");
    check({8'h00, local_wr_data}, 16'h0006, "local data");
  endtask : t_channels

  task automatic t_order_and_soft_reset;
    int n0;
    wr(cfg_pkg::ADDR_PORT_CFG, 8'h40, 1'b0);
    check({15'h0, lsb_first}, 16'h0001, "order from high copy");
    rd_chk(cfg_pkg::ADDR_PORT_CFG, 1'b1, 8'h5a);
    wr(cfg_pkg::ADDR_PORT_CFG, 8'h00, 1'b1);
    check({15'h0, lsb_first}, 16'h0000, "order cleared");
    wr(cfg_pkg::ADDR_PORT_CFG, 8'h02, 1'b0);
    check({15'h0, lsb_first}, 16'h0001, "order from low copy");
    n0 = n_srst;
    wr(cfg_pkg::ADDR_PORT_CFG, 8'h62, 1'b1);
    check(16'(n_srst - n0), 16'h0001, "soft reset pulses");
    check({8'h00, channel_enable}, 16'h00ff, "enables after soft reset");
    check({14'h0, speed_mode}, 16'h0000, "speed after soft reset");
    check({15'h0, lsb_first}, 16'h0001, "order kept");
    rd_chk(cfg_pkg::ADDR_PORT_CFG, 1'b1, 8'h5a);
    rd_chk(cfg_pkg::ADDR_CHAN_LOWER, 1'b1, 8'h3f);
    wr(cfg_pkg::ADDR_CHAN_UPPER, 8'h01, 1'b1);
    wr(cfg_pkg::ADDR_PORT_CFG, 8'h44, 1'b1);
    check(16'(n_srst - n0), 16'h0002, "low copy soft reset");
    check({8'h00, channel_enable}, 16'h00ff, "enables after second reset");
    rd_chk(cfg_pkg::ADDR_PORT_CFG, 1'b1, 8'h5a);
  endtask : t_order_and_soft_reset

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    srst = 1'b0;
    #1 srst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 srst = 1'b0;
    repeat (6) @(posedge clk_sys);
    t_defaults();
    t_speed();
    t_channels();
    t_order_and_soft_reset();
    end_of_test();
  end
  initial begin
    #500000;
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    end_of_test();
  end
endmodule : chip_config_channel_index_regs_test
